//--- srb_top.sv
// serial link receiver with status flags, receive buffer and register port
module srb_top (
    input  wire logic        clk_sys,         // system clock
    input  wire logic        reset,           // synchronous reset
    input  wire logic        ce,              // clock enable
    input  wire logic [4:0]  avs_address,     // byte address
    input  wire logic        avs_read,        // read request
    input  wire logic        avs_write,       // write request
    input  wire logic [31:0] avs_writedata,   // write data
    input  wire logic [3:0]  avs_byteenable,  // byte lanes
    output logic      [31:0] avs_readdata,    // read data
    output logic             avs_waitrequest, // stall
    input  wire logic        link_clk,        // serial clock pin
    input  wire logic        serial_in,       // serial data pin
    input  wire logic        ste_in,          // select / enable pin
    output logic             serial_out,      // serial data out
    output logic             serial_out_en,   // serial out drive
    output logic             irq              // level interrupt
);
    // synchronised pins
    logic [2:0] pins_q;
    srb_sync #(.W(3)) u_sync (
        .clk_sys (clk_sys),
        .ce      (ce),
        .reset   (reset),
        .d       ({ste_in, serial_in, link_clk}),
        .q       (pins_q)
    );

    // registers and state
    logic [7:0] control;
    logic       loopback_enable;
    logic       bus_conflict_error;
    logic       overrun_error;
    logic       busy_flag;
    logic [7:0] receive_buffer;
    logic [7:0] tx_data;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic       rx_unread;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [3:0] bit_count;
    logic       first_done;
    logic       sclk_prev;

    // control field decode
    wire        sw_reset  = control[srb_pkg::CTL_SWRST];
    wire        master    = control[srb_pkg::CTL_MASTER];
    wire [1:0]  wire_mode = control[srb_pkg::CTL_MODE_LO +: 2];
    wire        char7     = control[srb_pkg::CTL_CHAR7];
    wire        msb_first = control[srb_pkg::CTL_MSB];
    wire        cpol      = control[srb_pkg::CTL_CPOL];
    wire        cpha      = control[srb_pkg::CTL_CPHA];
    wire [3:0]  char_len  = char7 ? srb_pkg::LEN7 : srb_pkg::LEN8;
    wire        four_wire = (wire_mode == srb_pkg::MODE_4W_HIGH) ||
                            (wire_mode == srb_pkg::MODE_4W_LOW);
    wire        ste_act   = (wire_mode == srb_pkg::MODE_4W_HIGH) ? pins_q[2]
                                                                 : ~pins_q[2];

    // link edge detection on the sampled serial clock
    wire        sclk      = pins_q[0];
    wire        sclk_edge = (sclk != sclk_prev);
    wire        lead_edge = sclk_edge && (sclk != cpol);
    wire        trail_edge = sclk_edge && (sclk == cpol);
    wire        frame_en  = !four_wire || master || ste_act;
    wire        cap_edge  = frame_en && (cpha ? trail_edge : lead_edge);
    wire        shf_edge  = frame_en && (cpha ? lead_edge : trail_edge);
    wire        conflict  = four_wire && master && ste_act;

    // receive data source, loopback taps the transmit output
    wire        rx_bit    = loopback_enable ? serial_out : pins_q[1];

    // next receive shift value in either bit order
    wire [7:0]  shift_msb = {rx_shift[6:0], rx_bit};
    wire [7:0]  shift_lsb = char7 ? {1'b0, rx_bit, rx_shift[6:1]}
                                  : {rx_bit, rx_shift[7:1]};
    wire [7:0]  next_rx_shift = msb_first ? shift_msb : shift_lsb;
    wire [3:0]  next_count = bit_count + 4'h1;
    wire        char_done = cap_edge && (next_count == char_len);
    // seven-bit character right-justified, top bit forced low
    wire [7:0]  next_rxbuf = char7 ? {1'b0, next_rx_shift[6:0]}
                                   : next_rx_shift;

    // transmit bit selection
    wire [7:0]  tx_adv    = msb_first ? {tx_shift[6:0], 1'b0}
                                      : {1'b0, tx_shift[7:1]};
    wire        tx_top    = char7 ? tx_shift[6] : tx_shift[7];
    wire        tx_bit    = msb_first ? tx_top : tx_shift[0];

    // bus decode
    wire        bus_req   = avs_read || avs_write;
    wire        accept    = bus_req && !avs_waitrequest;
    wire        wr_acc    = accept && avs_write && avs_byteenable[0];
    wire        rd_acc    = accept && avs_read;
    wire        hit_ctl   = (avs_address == srb_pkg::OFF_CONTROL);
    wire        hit_st    = (avs_address == srb_pkg::OFF_STATUS);
    wire        hit_rxb   = (avs_address == srb_pkg::OFF_RXBUF);
    wire        hit_tx    = (avs_address == srb_pkg::OFF_TXDATA);
    wire        hit_is    = (avs_address == srb_pkg::OFF_IRQ_STAT);
    wire        hit_im    = (avs_address == srb_pkg::OFF_IRQ_MASK);
    wire [7:0]  wdata     = avs_writedata[7:0];
    wire        rxbuf_rd  = rd_acc && hit_rxb;
    wire        st_wr     = wr_acc && hit_st;

    // receive buffer read value, top bit reads zero in seven-bit mode
    wire [7:0]  rxbuf_val = {receive_buffer[7] & ~char7,
                             receive_buffer[6:0]};

    // status read value, unused bits read zero
    wire [7:0]  status_rd = {loopback_enable, bus_conflict_error,
                             overrun_error, 4'h0, busy_flag};
    wire [7:0]  rd_mux    = hit_ctl ? control :
                            hit_st  ? status_rd :
                            hit_rxb ? rxbuf_val :
                            hit_tx  ? tx_data :
                            hit_is  ? {5'h00, irq_status} :
                            hit_im  ? {5'h00, irq_mask} : 8'h00;

    // hardware events
    wire        ev_rx      = char_done;
    wire        ev_overrun = char_done && rx_unread;
    wire        ev_conf    = conflict;
    wire [2:0]  ev_vec     = {ev_conf, ev_overrun, ev_rx};

    // flag next values: hardware set wins over any clear
    wire [2:0]  w1c        = (wr_acc && hit_is) ? wdata[2:0] : 3'h0;
    wire [2:0]  rd_clr     = rxbuf_rd ? 3'h7 : 3'h0;
    wire [2:0]  next_irq_status = (irq_status & ~w1c & ~rd_clr) | ev_vec;
    wire        next_overrun = ev_overrun ||
                               (st_wr ? wdata[srb_pkg::ST_OVERRUN]
                                      : overrun_error && !rxbuf_rd);
    wire        next_conflict = ev_conf ||
                                (st_wr ? wdata[srb_pkg::ST_CONFLICT]
                                       : bus_conflict_error && !rxbuf_rd);

    // bus handshake: answer one cycle after the request appears
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (ce) begin
            if (bus_req && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= {24'h00_0000, rd_mux};
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // software-owned registers outside the link reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            control  <= srb_pkg::CTL_RESET;
            tx_data  <= 8'h00;
            irq_mask <= srb_pkg::IRQ_RESET;
        end else if (ce) begin
            if (wr_acc && hit_ctl) control <= wdata;
            if (wr_acc && hit_tx) tx_data <= wdata;
            if (wr_acc && hit_im) irq_mask <= wdata[2:0];
        end
    end

    // status flags, held clear during software reset
    always_ff @(posedge clk_sys) begin
        if (reset || (ce && sw_reset)) begin
            loopback_enable    <= srb_pkg::ST_RESET[srb_pkg::ST_LOOPBACK];
            bus_conflict_error <= srb_pkg::ST_RESET[srb_pkg::ST_CONFLICT];
            overrun_error      <= srb_pkg::ST_RESET[srb_pkg::ST_OVERRUN];
            busy_flag          <= srb_pkg::ST_RESET[srb_pkg::ST_BUSY];
            irq_status         <= srb_pkg::IRQ_RESET;
        end else if (ce) begin
            if (st_wr) loopback_enable <= wdata[srb_pkg::ST_LOOPBACK];
            bus_conflict_error <= next_conflict;
            overrun_error      <= next_overrun;
            busy_flag          <= (bit_count != 4'h0) && !char_done;
            irq_status         <= next_irq_status;
        end
    end

    // receive shifter and buffer
    always_ff @(posedge clk_sys) begin
        if (reset || (ce && sw_reset)) begin
            rx_shift       <= 8'h00;
            bit_count      <= 4'h0;
            receive_buffer <= 8'h00;
            rx_unread      <= 1'b0;
            sclk_prev      <= 1'b0;
        end else if (ce) begin
            sclk_prev <= sclk;
            if (four_wire && !master && !ste_act) begin
                bit_count <= 4'h0; // deselect aborts a partial character
            end else if (cap_edge) begin
                rx_shift  <= next_rx_shift;
                bit_count <= char_done ? 4'h0 : next_count;
            end
            if (char_done) begin
                receive_buffer <= next_rxbuf;
                rx_unread      <= 1'b1;
            end else if (rxbuf_rd) begin
                rx_unread <= 1'b0;
            end
        end
    end

    // transmit shifter, reloaded between characters
    always_ff @(posedge clk_sys) begin
        if (reset || (ce && sw_reset)) begin
            tx_shift   <= 8'h00;
            first_done <= 1'b0;
        end else if (ce) begin
            if (bit_count == 4'h0 && !first_done && !shf_edge) begin
                tx_shift <= tx_data;
            end else if (shf_edge) begin
                if (cpha && !first_done) begin
                    first_done <= 1'b1; // first leading edge only presents
                end else begin
                    tx_shift <= tx_adv;
                end
            end
            if (char_done) first_done <= 1'b0;
        end
    end

    // pin and interrupt outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
            irq           <= 1'b0;
        end else if (ce) begin
            serial_out    <= tx_bit;
            serial_out_en <= !sw_reset && frame_en;
            irq           <= |(irq_status & irq_mask);
        end
    end
endmodule // srb_top

//--- srb_pkg.sv
// package: register map, fields and reset values of the serial receive block
package srb_pkg;
    // register byte offsets (word aligned)
    localparam logic [4:0] OFF_CONTROL  = 5'h00;
    localparam logic [4:0] OFF_STATUS   = 5'h04;
    localparam logic [4:0] OFF_RXBUF    = 5'h08;
    localparam logic [4:0] OFF_TXDATA   = 5'h0c;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h14;
    // control register fields
    localparam int CTL_SWRST   = 0;
    localparam int CTL_MASTER  = 1;
    localparam int CTL_MODE_LO = 2;
    localparam int CTL_CHAR7   = 4;
    localparam int CTL_MSB     = 5;
    localparam int CTL_CPOL    = 6;
    localparam int CTL_CPHA    = 7;
    localparam logic [7:0] CTL_RESET = 8'h01;
    // serial_status fields
    localparam int ST_LOOPBACK = 7;
    localparam int ST_CONFLICT = 6;
    localparam int ST_OVERRUN  = 5;
    localparam int ST_BUSY     = 0;
    localparam logic [7:0] ST_RESET = 8'h00;
    // interrupt status / mask fields
    localparam int IRQ_RX       = 0;
    localparam int IRQ_OVERRUN  = 1;
    localparam int IRQ_CONFLICT = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // bits per character
    localparam logic [3:0] LEN8 = 4'h8;
    localparam logic [3:0] LEN7 = 4'h7;
    // wire modes
    localparam logic [1:0] MODE_3WIRE   = 2'h0;
    localparam logic [1:0] MODE_4W_HIGH = 2'h1;
    localparam logic [1:0] MODE_4W_LOW  = 2'h2;
endpackage : srb_pkg

//--- srb_sync.sv
// three-stage pin synchroniser with agreement filter
module srb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys, // system clock
    input  wire logic         ce,      // clock enable
    input  wire logic         reset,   // synchronous reset
    input  wire logic [W-1:0] d,       // asynchronous pins
    output logic      [W-1:0] q        // filtered level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;
    logic [W-1:0] agree;

    // take a bit only once stages two and three agree, else hold
    assign agree  = ~(s2 ^ s3);
    assign next_q = (s3 & agree) | (q & ~agree);

    // sampling chain
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else if (ce) begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule // srb_sync

//--- srb_checker.sv
// checker: register-port handshake and read-data relations
module srb_checker (
    input wire logic        clk_sys,         // system clock
    input wire logic        reset,           // synchronous reset
    input wire logic        ce,              // clock enable
    input wire logic [4:0]  avs_address,     // byte address
    input wire logic        avs_read,        // read request
    input wire logic        avs_write,       // write request
    input wire logic [31:0] avs_writedata,   // write data
    input wire logic [3:0]  avs_byteenable,  // byte lanes
    input wire logic [31:0] avs_readdata,    // read data
    input wire logic        avs_waitrequest, // stall
    input wire logic        serial_out_en,   // serial out drive
    input wire logic        irq              // level interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic char7; // seven-bit mode as last written
    logic rd_ok; // read completing this cycle
    assign rd_ok = avs_read && !avs_waitrequest;
    // track the character length bit of control
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            char7 <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                     && avs_address == srb_pkg::OFF_CONTROL) begin
            char7 <= avs_writedata[srb_pkg::CTL_CHAR7];
        end
    end
    AST_ANSWER: assert property (
        ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in the next cycle");
    AST_WAIT_ONE: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_IDLE: assert property (
        !avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without a request");
    AST_RESET: assert property (
        $past(reset) |-> avs_waitrequest && !irq && !serial_out_en)
        else $error("outputs not idle after reset");
    AST_RDHI: assert property (
        rd_ok |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_UNMAPPED: assert property (
        rd_ok && avs_address > 5'h17 |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    AST_STATUS: assert property (
        rd_ok && avs_address == srb_pkg::OFF_STATUS |->
        avs_readdata[4:1] == 4'h0) else $error("unused status bits set");
    AST_CHAR7: assert property (
        rd_ok && char7 && avs_address == srb_pkg::OFF_RXBUF |->
        !avs_readdata[7]) else $error("top bit set in seven-bit mode");
    // main scenarios reached
    cover property (rd_ok && char7 && avs_address == srb_pkg::OFF_RXBUF);
    cover property ($rose(irq));
    cover property (rd_ok && avs_address == srb_pkg::OFF_STATUS);
endmodule // srb_checker

//--- srb_peer.sv
// peer link master: drives clock, data and select toward the block
module srb_peer (
    output logic link_clk,  // link clock, idles low
    output logic serial_in, // data toward the block
    output logic ste_in     // select line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        link_clk  = 1'b0;
        serial_in = 1'b0;
        ste_in    = 1'b1;
    end
    // msb first, data set half a period before each rising edge
    task automatic send(input logic [7:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = d[i];
            #32 link_clk = 1'b1;
            #32 link_clk = 1'b0;
        end
        serial_in = ~serial_in; // released line shows no stale bit
        #200;
    endtask
    task automatic sel(input logic v);
        ste_in = v;
    endtask
endmodule // srb_peer

//--- tb_srb_top.sv
// testbench: register, link, interrupt and error-flag scenarios
module tb_srb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, irq, serial_out, serial_out_en;
    logic        link_clk, serial_in, ste_in;
    logic [15:0] q[$];
    logic [15:0] note;
    logic [7:0]  b1, b2, b3;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          seed;
    always #2 clk_sys = ~clk_sys;
    srb_top u_srb_top (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link_clk(link_clk),
        .serial_in(serial_in), .ste_in(ste_in), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .irq(irq));
    srb_peer u_srb_peer (.link_clk(link_clk), .serial_in(serial_in),
        .ste_in(ste_in));
    task automatic stop_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic acc(input logic [4:0] a, input logic w,
                       input logic [7:0] d);
        int t;
        t = 0;
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge clk_sys);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            stop_test();
        end
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        q.push_back({m, e});
        acc(a, 1'b0, 8'h00);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acc(a, 1'b1, d);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_sys);
        chk({7'h00, irq}, {7'h00, e});
    endtask
    // monitor: oldest note against each completed read
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && q.size() > 0) begin
            note = q.pop_front();
            chk(avs_readdata[7:0] & note[15:8], note[7:0]);
        end
    end
    initial begin
        seed = $urandom(5973);
        b1 = 8'($urandom());
        b2 = 8'($urandom());
        b3 = 8'($urandom());
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        chk({7'h00, serial_out_en}, 8'h00);
        rd(srb_pkg::OFF_CONTROL, 8'h01, 8'hff);
        rd(srb_pkg::OFF_STATUS, 8'h00, 8'hff);
        rd(srb_pkg::OFF_RXBUF, 8'h00, 8'hff);
        rd(srb_pkg::OFF_IRQ_MASK, 8'h00, 8'hff);
        rd(5'h18, 8'h00, 8'hff);
        wr(srb_pkg::OFF_CONTROL, 8'h20);
        fork
            u_srb_peer.send(b1, 8);
            begin
                repeat (60) @(posedge clk_sys);
                chk({7'h00, serial_out_en}, 8'h01);
                rd(srb_pkg::OFF_STATUS, 8'h01, 8'h01);
            end
        join
        rd(srb_pkg::OFF_STATUS, 8'h00, 8'hff);
        irq_is(1'b0);
        wr(srb_pkg::OFF_IRQ_MASK, 8'h07);
        irq_is(1'b1);
        rd(srb_pkg::OFF_RXBUF, b1, 8'hff);
        irq_is(1'b0);
        u_srb_peer.send(b2, 8);
        u_srb_peer.send(b3, 8);
        rd(srb_pkg::OFF_STATUS, 8'h20, 8'hff);
        rd(srb_pkg::OFF_IRQ_STAT, 8'h03, 8'hff);
        wr(srb_pkg::OFF_IRQ_STAT, 8'h02);
        rd(srb_pkg::OFF_IRQ_STAT, 8'h01, 8'hff);
        rd(srb_pkg::OFF_RXBUF, b3, 8'hff);
        rd(srb_pkg::OFF_STATUS, 8'h00, 8'hff);
        irq_is(1'b0);
        wr(srb_pkg::OFF_CONTROL, 8'h30);
        u_srb_peer.send(b1, 7);
        rd(srb_pkg::OFF_RXBUF, {1'b0, b1[6:0]}, 8'hff);
        wr(srb_pkg::OFF_RXBUF, 8'hff);
        rd(srb_pkg::OFF_RXBUF, {1'b0, b1[6:0]}, 8'hff);
        avs_byteenable <= 4'he;
        wr(srb_pkg::OFF_STATUS, 8'h80);
        avs_byteenable <= 4'hf;
        rd(srb_pkg::OFF_STATUS, 8'h00, 8'hff);
        // loopback: bit 7 set, overrun and conflict bits written as zero
        wr(srb_pkg::OFF_CONTROL, 8'h20);
        wr(srb_pkg::OFF_TXDATA, b2);
        wr(srb_pkg::OFF_STATUS, 8'h80);
        rd(srb_pkg::OFF_STATUS, 8'h80, 8'hff);
        u_srb_peer.send(~b2, 8);
        rd(srb_pkg::OFF_RXBUF, b2, 8'hff);
        wr(srb_pkg::OFF_STATUS, 8'h00);
        // four-wire master with select active flags a conflict
        wr(srb_pkg::OFF_CONTROL, 8'h26);
        rd(srb_pkg::OFF_STATUS, 8'h40, 8'h40);
        u_srb_peer.sel(1'b0);
        repeat (10) @(posedge clk_sys);
        rd(srb_pkg::OFF_RXBUF, 8'h00, 8'h00);
        rd(srb_pkg::OFF_STATUS, 8'h00, 8'h60);
        // clock enable low: a character on the link must leave no trace
        ce <= 1'b0;
        u_srb_peer.send(b1, 8);
        @(posedge clk_sys);
        ce <= 1'b1;
        rd(srb_pkg::OFF_IRQ_STAT, 8'h00, 8'h01);
        rd(srb_pkg::OFF_RXBUF, b2, 8'hff);
        stop_test();
    end
endmodule // tb_srb_top
bind srb_top srb_checker u_srb_checker (.clk_sys(clk_sys), .reset(reset),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_out_en(serial_out_en),
    .irq(irq));
